// file: hdl/pmlc_pkg.sv
/*
 * Package for the MAC link configuration register bank: offsets, field
 * positions, reset values, timing constants and the carrier structs.
 * Assumes a single 50 MHz clock and a plain register port.
 */
package pmlc_pkg;

    // =====================================================================
    // register indices, as they appear on the address port
    // =====================================================================
    localparam logic [7:0] RGMII_CONTROL_IDX        = 8'h32;
    localparam logic [7:0] RGMII_CONTROL_SECOND_IDX = 8'h33;
    localparam logic [7:0] SERIAL_AUTONEG_STATUS_IDX = 8'h37;
    localparam logic [7:0] FAST_ETHERNET_CONFIG_IDX = 8'h43;
    localparam logic [7:0] VITERBI_CONFIG_IDX       = 8'h53;

    // =====================================================================
    // field positions
    // =====================================================================
    localparam int RGMII_EN_BIT        = 7;
    localparam int RX_HALF_LO          = 5;
    localparam int TX_HALF_LO          = 3;
    localparam int TX_CLK_SHIFT_BIT    = 1;
    localparam int RX_CLK_SHIFT_BIT    = 0;
    localparam int BYPASS_BIT          = 4;
    localparam int BYPASS_DLY_BIT      = 3;
    localparam int LOW_LAT_BIT         = 2;
    localparam int PAGE_RX_BIT         = 1;
    localparam int NEG_DONE_BIT        = 0;
    localparam int TIMEOUT_OFF_BIT     = 11;
    localparam int RECOVERY_LO         = 7;
    localparam int FORCE_LINK_BIT      = 6;
    localparam int TERNARY_BIT         = 5;
    localparam int GAP_BIT             = 4;
    localparam int SCRAMBLER_OFF_BIT   = 2;
    localparam int ODD_NIBBLE_BIT      = 1;
    localparam int EARLY_VALID_BIT     = 0;
    localparam int IDLE_LIMIT_LO       = 0;

    // =====================================================================
    // reset values
    // =====================================================================
    localparam logic       RGMII_EN_RST      = 1'h1;
    localparam logic [1:0] HALF_LEVEL_RST    = 2'h2;
    localparam logic [3:0] RECOVERY_RST      = 4'hF;
    localparam logic       TERNARY_RST       = 1'h1;
    localparam logic [3:0] IDLE_LIMIT_RST    = 4'h5;
    localparam logic [11:0] VITERBI_UPPER_RO = 12'h205;

    // =====================================================================
    // timing
    // =====================================================================
    localparam int CLK_HZ            = 50_000_000;
    localparam int TIMEOUT_US        = 1500;
    localparam int TIMEOUT_CYCLES    = CLK_HZ / 1_000_000 * TIMEOUT_US;
    localparam int MS_CYCLES         = CLK_HZ / 1000;

    // =====================================================================
    // carriers
    // =====================================================================
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pmlc_bus_req_t;

    typedef struct packed {
        logic       rgmii_enable;
        logic [1:0] rx_fifo_half_level;
        logic [1:0] tx_fifo_half_level;
        logic       tx_clock_shift;
        logic       rx_clock_shift;
        logic       async_fifo_bypass;
        logic       bypass_rx_clock_delay;
        logic       low_latency;
        logic       force_link_good;
        logic       enhanced_ternary_detect;
        logic       enhanced_gap_detect;
        logic       scrambler_off;
        logic       odd_nibble_detect;
        logic       early_receive_valid;
    } pmlc_ctrl_t;

endpackage

// file: hdl/pmlc_regs.sv
/*
 * MAC link configuration register bank with the descrambler timeout,
 * recovery timer and Viterbi idle detector that the registers steer.
 * Assumes status and symbol inputs come from logic on ref_clk_i, except
 * the serial negotiation flags which arrive from another domain.
 */
// The implementer's own choice: strobed register access.
module pmlc_regs #(
    parameter int TIMEOUT_CYCLES = pmlc_pkg::TIMEOUT_CYCLES,
    parameter int MS_CYCLES      = pmlc_pkg::MS_CYCLES
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_i,
    input  wire logic [7:0]           addr_i,
    input  wire logic [15:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic [15:0]               rdata_o,
    input  wire logic                 page_received_i,
    input  wire logic                 serial_negotiation_done_i,
    input  wire logic                 rx_packet_active_i,
    input  wire logic                 idle_symbol_i,
    input  wire logic                 link_good_i,
    output pmlc_pkg::pmlc_ctrl_t      ctrl_o,
    output logic                      link_good_o,
    output logic                      rx_stop_o,
    output logic                      descrambler_recovering_o,
    output logic                      idle_mode_o
);

    // =====================================================================
    // registers
    // =====================================================================
    pmlc_pkg::pmlc_ctrl_t ctrl;
    logic                 timeout_off;
    logic [3:0]           recovery_time;
    logic [3:0]           idle_limit;
    logic [2:0]           page_sync;
    logic [2:0]           done_sync;
    logic                 page_received;
    logic                 negotiation_done;
    logic [31:0]          packet_count;
    logic [31:0]          ms_count;
    logic [3:0]           recovery_left;
    logic                 recovering;
    logic [3:0]           idle_count;
    logic                 idle_mode;
    logic                 rx_stop;
    logic                 link_good;
    logic [15:0]          rdata;

    pmlc_pkg::pmlc_bus_req_t req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // =====================================================================
    // decode
    // =====================================================================
    function automatic logic hit(input pmlc_pkg::pmlc_bus_req_t r,
                                 input logic [7:0] idx);
        hit = r.wr && (r.addr == idx);
    endfunction

    wire wr_ctl  = hit(req, pmlc_pkg::RGMII_CONTROL_IDX);
    wire wr_ctl2 = hit(req, pmlc_pkg::RGMII_CONTROL_SECOND_IDX);
    wire wr_fe   = hit(req, pmlc_pkg::FAST_ETHERNET_CONFIG_IDX);
    wire wr_vit  = hit(req, pmlc_pkg::VITERBI_CONFIG_IDX);

    // reserved bits read as zero by construction; the Viterbi word's upper bits read VITERBI_UPPER_RO
    wire [15:0] rd_ctl = {8'h00, ctrl.rgmii_enable,
                          ctrl.rx_fifo_half_level,
                          ctrl.tx_fifo_half_level, 1'b0,
                          ctrl.tx_clock_shift, ctrl.rx_clock_shift};
    wire [15:0] rd_ctl2 = {11'h000, ctrl.async_fifo_bypass,
                           ctrl.bypass_rx_clock_delay,
                           ctrl.low_latency, 2'h0};
    wire [15:0] rd_sts = {14'h0000, page_received,
                          negotiation_done};
    wire [15:0] rd_fe = {4'h0, timeout_off, recovery_time,
                         ctrl.force_link_good,
                         ctrl.enhanced_ternary_detect,
                         ctrl.enhanced_gap_detect, 1'b0,
                         ctrl.scrambler_off, ctrl.odd_nibble_detect,
                         ctrl.early_receive_valid};
    wire [15:0] rd_vit = {pmlc_pkg::VITERBI_UPPER_RO, idle_limit};

    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                pmlc_pkg::RGMII_CONTROL_IDX:         next_rdata = rd_ctl;
                pmlc_pkg::RGMII_CONTROL_SECOND_IDX:  next_rdata = rd_ctl2;
                pmlc_pkg::SERIAL_AUTONEG_STATUS_IDX: next_rdata = rd_sts;
                pmlc_pkg::FAST_ETHERNET_CONFIG_IDX:  next_rdata = rd_fe;
                pmlc_pkg::VITERBI_CONFIG_IDX:        next_rdata = rd_vit;
                default:                             next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // =====================================================================
    // control writes
    // =====================================================================
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl                        <= '0;
            ctrl.rgmii_enable           <= pmlc_pkg::RGMII_EN_RST;
            ctrl.rx_fifo_half_level     <= pmlc_pkg::HALF_LEVEL_RST;
            ctrl.tx_fifo_half_level     <= pmlc_pkg::HALF_LEVEL_RST;
            ctrl.enhanced_ternary_detect <= pmlc_pkg::TERNARY_RST;
            timeout_off                 <= 1'b0;
            recovery_time               <= pmlc_pkg::RECOVERY_RST;
            idle_limit                  <= pmlc_pkg::IDLE_LIMIT_RST;
        end else begin
            if (wr_ctl) begin
                ctrl.rgmii_enable <= wdata_i[pmlc_pkg::RGMII_EN_BIT];
                ctrl.rx_fifo_half_level <=
                    wdata_i[pmlc_pkg::RX_HALF_LO +: 2];
                ctrl.tx_fifo_half_level <=
                    wdata_i[pmlc_pkg::TX_HALF_LO +: 2];
                ctrl.tx_clock_shift <=
                    wdata_i[pmlc_pkg::TX_CLK_SHIFT_BIT];
                ctrl.rx_clock_shift <=
                    wdata_i[pmlc_pkg::RX_CLK_SHIFT_BIT];
            end
            if (wr_ctl2) begin
                ctrl.async_fifo_bypass <=
                    wdata_i[pmlc_pkg::BYPASS_BIT];
                ctrl.bypass_rx_clock_delay <=
                    wdata_i[pmlc_pkg::BYPASS_DLY_BIT];
                ctrl.low_latency <= wdata_i[pmlc_pkg::LOW_LAT_BIT];
            end
            if (wr_fe) begin
                timeout_off <= wdata_i[pmlc_pkg::TIMEOUT_OFF_BIT];
                recovery_time <=
                    wdata_i[pmlc_pkg::RECOVERY_LO +: 4];
                ctrl.force_link_good <=
                    wdata_i[pmlc_pkg::FORCE_LINK_BIT];
                ctrl.enhanced_ternary_detect <=
                    wdata_i[pmlc_pkg::TERNARY_BIT];
                ctrl.enhanced_gap_detect <=
                    wdata_i[pmlc_pkg::GAP_BIT];
                ctrl.scrambler_off <=
                    wdata_i[pmlc_pkg::SCRAMBLER_OFF_BIT];
                ctrl.odd_nibble_detect <=
                    wdata_i[pmlc_pkg::ODD_NIBBLE_BIT];
                ctrl.early_receive_valid <=
                    wdata_i[pmlc_pkg::EARLY_VALID_BIT];
            end
            if (wr_vit) begin
                idle_limit <= wdata_i[pmlc_pkg::IDLE_LIMIT_LO +: 4];
            end
        end
    end

    // =====================================================================
    // serial negotiation status, from the serdes domain
    // =====================================================================
    // status writes never reach these flops, they only follow the inputs
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            page_sync        <= 3'h0;
            done_sync        <= 3'h0;
            page_received    <= 1'b0;
            negotiation_done <= 1'b0;
        end else begin
            page_sync <= {page_sync[1:0], page_received_i};
            done_sync <= {done_sync[1:0], serial_negotiation_done_i};
            if (page_sync[2] == page_sync[1]) begin
                page_received <= page_sync[2];
            end
            if (done_sync[2] == done_sync[1]) begin
                negotiation_done <= done_sync[2];
            end
        end
    end

    // =====================================================================
    // descrambler timeout and recovery
    // =====================================================================
    wire packet_too_long = rx_packet_active_i &&
                           (packet_count >= 32'(TIMEOUT_CYCLES - 1));
    // a set bit disables the stop; clear stops reception on a violation
    wire violation = packet_too_long && !timeout_off && !recovering;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            packet_count  <= 32'h0000_0000;
            ms_count      <= 32'h0000_0000;
            recovery_left <= 4'h0;
            recovering    <= 1'b0;
            rx_stop       <= 1'b0;
        end else begin
            if (!rx_packet_active_i || recovering) begin
                packet_count <= 32'h0000_0000;
            end else if (!packet_too_long) begin
                packet_count <= packet_count + 32'h0000_0001;
            end
            if (violation) begin
                recovering    <= 1'b1;
                rx_stop       <= 1'b1;
                recovery_left <= recovery_time;
                ms_count      <= 32'h0000_0000;
            end else if (recovering) begin
                if (ms_count >= 32'(MS_CYCLES - 1)) begin
                    ms_count <= 32'h0000_0000;
                    if (recovery_left == 4'h0) begin
                        recovering <= 1'b0;
                        rx_stop    <= 1'b0;
                    end else begin
                        recovery_left <= recovery_left - 4'h1;
                    end
                end else begin
                    ms_count <= ms_count + 32'h0000_0001;
                end
            end
        end
    end

    // =====================================================================
    // Viterbi idle detector and link report
    // =====================================================================
    // a threshold of zero makes any idle symbol count; software keeps 5/4
    wire idle_reached = idle_symbol_i &&
                        ((idle_count + 4'h1) >= idle_limit);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            idle_count <= 4'h0;
            idle_mode  <= 1'b0;
            link_good  <= 1'b0;
        end else begin
            if (!idle_symbol_i) begin
                idle_count <= 4'h0;
                idle_mode  <= 1'b0;
            end else if (idle_reached) begin
                idle_mode <= 1'b1;
            end else begin
                idle_count <= idle_count + 4'h1;
            end
            link_good <= link_good_i || ctrl.force_link_good;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign rdata_o                  = rdata;
    assign ctrl_o                   = ctrl;
    assign link_good_o              = link_good;
    assign rx_stop_o                = rx_stop;
    assign descrambler_recovering_o = recovering;
    assign idle_mode_o              = idle_mode;

endmodule

// file: test/pmlc_regs_properties.sv
/*
 * Port checker for the MAC link configuration register bank.
 * Assumes it is bound to pmlc_regs: one clock, asynchronous high reset.
 */
module pmlc_regs_checker #(
    parameter int TIMEOUT_CYCLES = 20,
    parameter int MS_CYCLES      = 10
) (
    input wire logic                 ref_clk_i,
    input wire logic                 reset_i,
    input wire logic [7:0]           addr_i,
    input wire logic [15:0]          wdata_i,
    input wire logic                 wr_i,
    input wire logic                 rd_i,
    input wire logic [15:0]          rdata_o,
    input wire logic                 page_received_i,
    input wire logic                 serial_negotiation_done_i,
    input wire logic                 rx_packet_active_i,
    input wire logic                 idle_symbol_i,
    input wire logic                 link_good_i,
    input wire pmlc_pkg::pmlc_ctrl_t ctrl_o,
    input wire logic                 link_good_o,
    input wire logic                 rx_stop_o,
    input wire logic                 descrambler_recovering_o,
    input wire logic                 idle_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // helper state
    // =====================================================================
    logic [15:0] last_fast;
    int          active_len;

    // shadow of the last value written to the 100 Mbps config word
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            last_fast  <= 16'h07A0;
            active_len <= 0;
        end else begin
            if (wr_i && addr_i == pmlc_pkg::FAST_ETHERNET_CONFIG_IDX) begin
                last_fast <= wdata_i & 16'h0FF7;
            end
            active_len <= rx_packet_active_i ? active_len + 1 : 0;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_write(logic [7:0] idx);
        wr_i && addr_i == idx;
    endsequence

    sequence s_read(logic [7:0] idx);
        rd_i && addr_i == idx;
    endsequence

    // =====================================================================
    // assertions
    // =====================================================================
    a_rdata_quiet: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_ctrl_reserved: assert property (s_read(pmlc_pkg::RGMII_CONTROL_IDX)
        |=> rdata_o[15:8] == 8'h00 && !rdata_o[2])
        else $error("control word reserved bits not zero");
    a_status_reserved: assert property (
        s_read(pmlc_pkg::SERIAL_AUTONEG_STATUS_IDX)
        |=> rdata_o[15:2] == 14'h0000)
        else $error("status word reserved bits not zero");
    a_enable_fields: assert property (
        s_write(pmlc_pkg::RGMII_CONTROL_IDX) |=>
        {ctrl_o.rgmii_enable, ctrl_o.rx_fifo_half_level,
         ctrl_o.tx_fifo_half_level} == $past(wdata_i[7:3]) &&
        {ctrl_o.tx_clock_shift, ctrl_o.rx_clock_shift} == $past(wdata_i[1:0]))
        else $error("control word fields do not follow write");
    a_second_fields: assert property (
        s_write(pmlc_pkg::RGMII_CONTROL_SECOND_IDX) |=>
        {ctrl_o.async_fifo_bypass, ctrl_o.bypass_rx_clock_delay,
         ctrl_o.low_latency} == $past(wdata_i[4:2]))
        else $error("second control word fields do not follow write");
    a_fast_fields: assert property (
        s_write(pmlc_pkg::FAST_ETHERNET_CONFIG_IDX) |=>
        {ctrl_o.force_link_good, ctrl_o.enhanced_ternary_detect,
         ctrl_o.enhanced_gap_detect} == $past(wdata_i[6:4]) &&
        {ctrl_o.scrambler_off, ctrl_o.odd_nibble_detect,
         ctrl_o.early_receive_valid} == $past(wdata_i[2:0]))
        else $error("fast config fields do not follow write");
    a_fast_readback: assert property (
        s_read(pmlc_pkg::FAST_ETHERNET_CONFIG_IDX) |=> rdata_o == last_fast)
        else $error("fast config read back differs from last write");
    a_link_forced: assert property (1'b1 |=>
        link_good_o == $past(ctrl_o.force_link_good || link_good_i))
        else $error("link good output wrong");
    a_idle_drop: assert property (!idle_symbol_i |=> !idle_mode_o)
        else $error("idle mode held after a non idle symbol");
    a_idle_cause: assert property ($rose(idle_mode_o) |->
        $past(idle_symbol_i))
        else $error("idle mode rose without idle symbol");
    a_stop_cause: assert property ($rose(rx_stop_o) |->
        active_len >= TIMEOUT_CYCLES - 2)
        else $error("reception stopped before the packet timeout");
    a_recover_twin: assert property (
        descrambler_recovering_o == rx_stop_o)
        else $error("recovery flag differs from stop flag");
endmodule

bind pmlc_regs pmlc_regs_checker #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
    .MS_CYCLES     (MS_CYCLES)
) chk_u (
    .ref_clk_i                (ref_clk_i),
    .reset_i                  (reset_i),
    .addr_i                   (addr_i),
    .wdata_i                  (wdata_i),
    .wr_i                     (wr_i),
    .rd_i                     (rd_i),
    .rdata_o                  (rdata_o),
    .page_received_i          (page_received_i),
    .serial_negotiation_done_i(serial_negotiation_done_i),
    .rx_packet_active_i       (rx_packet_active_i),
    .idle_symbol_i            (idle_symbol_i),
    .link_good_i              (link_good_i),
    .ctrl_o                   (ctrl_o),
    .link_good_o              (link_good_o),
    .rx_stop_o                (rx_stop_o),
    .descrambler_recovering_o (descrambler_recovering_o),
    .idle_mode_o              (idle_mode_o)
);

// file: test/pmlc_mac_model.sv
/*
 * Far side model: line receiver and serial negotiation status feeding
 * the register bank. Assumes the bench calls its tasks one at a time.
 */
module pmlc_mac_model (
    input  wire logic ref_clk_i,
    output logic      page_received_o,
    output logic      negotiation_done_o,
    output logic      packet_active_o,
    output logic      idle_symbol_o,
    output logic      link_good_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        page_received_o    = 1'b0;
        negotiation_done_o = 1'b0;
        packet_active_o    = 1'b0;
        idle_symbol_o      = 1'b0;
        link_good_o        = 1'b0;
    end

    // =====================================================================
    // traffic
    // =====================================================================
    task automatic send_packet(input int n);
        @(posedge ref_clk_i);
        packet_active_o <= 1'b1;
        repeat (n) @(posedge ref_clk_i);
        packet_active_o <= 1'b0;
    endtask

    // exactly n idle symbols, then a data symbol ends the run
    task automatic send_idles(input int n);
        @(posedge ref_clk_i);
        idle_symbol_o <= 1'b1;
        repeat (n) @(posedge ref_clk_i);
        idle_symbol_o <= 1'b0;
    endtask

    task automatic set_status(input logic page, input logic done,
                              input logic good);
        @(posedge ref_clk_i);
        page_received_o    <= page;
        negotiation_done_o <= done;
        link_good_o        <= good;
    endtask
endmodule

// file: test/tb.sv
/*
 * Self-checking bench for pmlc_regs: register access, status, link
 * forcing, idle detection and packet timeout. Shortened time counts.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] FE = pmlc_pkg::FAST_ETHERNET_CONFIG_IDX;
    localparam logic [7:0] VT = pmlc_pkg::VITERBI_CONFIG_IDX;
    logic ref_clk_i, reset_i, wr_i, rd_i, page, done, pkt, idle, good;
    logic [7:0]           addr_i;
    logic [15:0]          wdata_i, rdata_o;
    pmlc_pkg::pmlc_ctrl_t ctrl_o;
    logic                 link_good_o, rx_stop_o, recovering, idle_mode_o;
    logic                 stop_seen, idle_seen;
    int                   n_mismatch = 0;
    int                   compares = 0;
    int                   stop_len, rec_len;
    logic [7:0]  idx_tab [5] = '{8'h32, 8'h33, 8'h37, 8'h43, 8'h53};
    logic [15:0] rst_tab [5] = '{16'h00D0, 16'h0000, 16'h0000,
                                 16'h07A0, 16'h2055};
    logic [15:0] rw_tab  [5] = '{16'h00FB, 16'h001C, 16'h0000,
                                 16'h0FF7, 16'h000F};
    logic [15:0] ro_tab  [5] = '{16'h0000, 16'h0000, 16'h0000,
                                 16'h0000, 16'h2050};

    pmlc_regs #(.TIMEOUT_CYCLES(20), .MS_CYCLES(10)) dut_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .page_received_i(page), .serial_negotiation_done_i(done),
        .rx_packet_active_i(pkt), .idle_symbol_i(idle),
        .link_good_i(good), .ctrl_o(ctrl_o), .link_good_o(link_good_o),
        .rx_stop_o(rx_stop_o), .descrambler_recovering_o(recovering),
        .idle_mode_o(idle_mode_o));
    pmlc_mac_model mac_u (
        .ref_clk_i(ref_clk_i), .page_received_o(page),
        .negotiation_done_o(done), .packet_active_o(pkt),
        .idle_symbol_o(idle), .link_good_o(good));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // sticky monitors: pulses may be shorter than a bus access
    always @(posedge ref_clk_i) begin
        if (idle_mode_o) idle_seen <= 1'b1;
        if (rx_stop_o) stop_seen <= 1'b1;
        if (rx_stop_o) stop_len <= stop_len + 1;
        if (recovering) rec_len <= rec_len + 1;
    end

    // =====================================================================
    // tasks
    // =====================================================================
    task automatic chk(input logic [15:0] g, input logic [15:0] e,
                       input string m);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e,
                          input string m);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e, m);
    endtask

    task automatic idle_try(input int n, input logic e);
        idle_seen <= 1'b0;
        mac_u.send_idles(n);
        repeat (3) @(posedge ref_clk_i);
        chk({15'h0, idle_seen}, {15'h0, e}, "idle mode");
    endtask

    task automatic stop_try(input logic [15:0] cfg, input logic e);
        wr_reg(FE, cfg);
        stop_seen <= 1'b0;
        stop_len  <= 0;
        rec_len   <= 0;
        mac_u.send_packet(30);
        repeat (100) @(posedge ref_clk_i);
        chk({15'h0, stop_seen}, {15'h0, e}, "reception stop");
        chk({15'h0, e ? stop_len inside {[10:30]} : stop_len == 0},
            16'h0001, "stop length");
        chk(16'(rec_len), e ? 16'h0014 : 16'h0000, "recovery length");
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        tally_and_finish;
    end

    // =====================================================================
    // tests
    // =====================================================================
    initial begin
        reset_i = 1'b1;
        wr_i    = 1'b0;
        rd_i    = 1'b0;
        addr_i  = 8'h00;
        wdata_i = 16'h0000;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        for (int r = 0; r < 5; r++) begin
            rd_chk(idx_tab[r], rst_tab[r], "reset value");
        end
        rd_chk(8'h40, 16'h0000, "unmapped read");
        for (int r = 0; r < 5; r++) begin
            for (int b = 0; b < 16; b++) begin
                wr_reg(idx_tab[r], 16'h0001 << b);
                rd_chk(idx_tab[r], ((16'h0001 << b) & rw_tab[r]) | ro_tab[r],
                       "walking bit");
            end
        end
        for (int r = 0; r < 5; r++) wr_reg(idx_tab[r], 16'hFFFF);
        #1 chk(ctrl_o, 16'hFFFF, "controls set");
        chk({15'h0, link_good_o}, 16'h0001, "forced link");
        for (int r = 0; r < 5; r++) wr_reg(idx_tab[r], 16'h0000);
        #1 chk(ctrl_o, 16'h0000, "controls clear");
        chk({15'h0, link_good_o}, 16'h0000, "unforced link");
        mac_u.set_status(1'b1, 1'b0, 1'b1);
        repeat (6) @(posedge ref_clk_i);
        chk({15'h0, link_good_o}, 16'h0001, "raw link");
        rd_chk(pmlc_pkg::SERIAL_AUTONEG_STATUS_IDX, 16'h0002, "page");
        mac_u.set_status(1'b1, 1'b1, 1'b0);
        repeat (6) @(posedge ref_clk_i);
        rd_chk(pmlc_pkg::SERIAL_AUTONEG_STATUS_IDX, 16'h0003, "done");
        wr_reg(VT, 16'h0005);
        idle_try(4, 1'b0);
        idle_try(5, 1'b1);
        wr_reg(VT, 16'h0004);
        idle_try(3, 1'b0);
        idle_try(4, 1'b1);
        stop_try(16'h0080, 1'b1);
        stop_try(16'h0880, 1'b0);
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd_chk(FE, 16'h07A0, "second reset");
        tally_and_finish;
    end
endmodule
